// [logic/gpp0_pkg.sv]
// Package for the port 0 general I/O block
package gpp0_pkg;

  // ---------------------------------------------------------------
  // Geometry
  // ---------------------------------------------------------------
  localparam int unsigned PORT_BITS = 7;
  localparam int unsigned BUS_BITS  = 8;

  // ---------------------------------------------------------------
  // Pin positions
  // ---------------------------------------------------------------
  localparam int unsigned TMR_B_POS = 0;
  localparam int unsigned TMR_A_POS = 1;
  localparam int unsigned NMI_POS   = 2;
  localparam int unsigned INT0_POS  = 3;
  localparam int unsigned INT1_POS  = 4;
  localparam int unsigned DBG_POS   = 5;
  localparam int unsigned INT3_POS  = 6;

  // ---------------------------------------------------------------
  // Reset values
  // ---------------------------------------------------------------
  localparam logic [6:0] DATA_RST = 7'h00;
  localparam logic [6:0] DIR_RST  = 7'h7f;
  localparam logic [6:0] ALT_RST  = 7'h00;
  localparam logic [6:0] FSEL_RST = 7'h00;
  localparam logic [6:0] FEXT_RST = 7'h00;
  localparam logic [6:0] PU_RST   = 7'h00;
  localparam logic [6:0] EDGE_RST = 7'h00;
  localparam logic       DBG_RST  = 1'b1;

  // ---------------------------------------------------------------
  // Register select codes for the software port
  // ---------------------------------------------------------------
  typedef enum logic [2:0] {
    GPP0_SEL_DATA,
    GPP0_SEL_DIR,
    GPP0_SEL_ALT,
    GPP0_SEL_FSEL,
    GPP0_SEL_FEXT,
    GPP0_SEL_PU,
    GPP0_SEL_FALL,
    GPP0_SEL_RISE
  } gpp0_sel_t;

  // Software access request
  typedef struct packed {
    logic       wr;
    logic       rd;
    logic       bit_op;
    gpp0_sel_t  sel;
    logic [2:0] bit_idx;
    logic [7:0] wdata;
  } gpp0_req_t;

  // Alternate function routing outputs
  typedef struct packed {
    logic       nmi_in;
    logic       ext_int0_in;
    logic       ext_int1_in;
    logic       ext_int2_in;
    logic       ext_int3_in;
    logic       conv_trig_in;
    logic       tmr_a_in;
    logic       tmr_b_in;
    logic       dbg_reset_in;
  } gpp0_alt_t;

endpackage

// [logic/gpp0_port.sv]
// Port 0 general I/O with alternate function routing
`timescale 1ns/10ps

module gpp0_port #(
  parameter int unsigned WIDTH = gpp0_pkg::PORT_BITS
) (
  // Clock and reset
  input  wire logic              clk,
  input  wire logic              rstn,
  // Software access
  input  wire gpp0_pkg::gpp0_req_t req,
  input  wire logic              debug_pin_enable_clr,
  output logic [7:0]             rdata,
  output logic                   rvalid,
  output logic                   debug_pin_enable_bit,
  // Pins
  input  wire logic [WIDTH-1:0]  pin_in,
  output logic [WIDTH-1:0]       pin_out,
  output logic [WIDTH-1:0]       pin_oe,
  output logic [WIDTH-1:0]       pin_pullup_en,
  output logic                   bit5_pulldown_en,
  // Alternate function side
  input  wire logic              timer_channel_a_io_out,
  input  wire logic              timer_channel_b_io_out,
  output gpp0_pkg::gpp0_alt_t    alt_in,
  output logic [WIDTH-1:0]       port_function_select_reg,
  output logic [WIDTH-1:0]       port_function_extension_reg,
  output logic [WIDTH-1:0]       falling_edge_select_reg,
  output logic [WIDTH-1:0]       rising_edge_select_reg
);

  // ---------------------------------------------------------------
  // Helpers
  // ---------------------------------------------------------------
  function automatic logic [7:0] widen(input logic [WIDTH-1:0] v);
    widen = {{(8-WIDTH){1'b0}}, v};
  endfunction

  function automatic logic [WIDTH-1:0] merge(input logic [WIDTH-1:0] cur,
                                             input gpp0_pkg::gpp0_req_t r);
    logic [7:0] t;
    t = widen(cur);
    if (r.bit_op) begin
      t[r.bit_idx] = r.wdata[0];
    end else begin
      t = r.wdata;
    end
    merge = t[WIDTH-1:0];
  endfunction

  // ---------------------------------------------------------------
  // Pin synchroniser
  // ---------------------------------------------------------------
  logic [WIDTH-1:0] sync1_q, sync1_d;
  logic [WIDTH-1:0] sync2_q, sync2_d;

  always_comb begin
    sync1_d = pin_in;
    sync2_d = sync1_q;
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      sync1_q <= '0;
      sync2_q <= '0;
    end else begin
      sync1_q <= sync1_d;
      sync2_q <= sync2_d;
    end
  end

  // ---------------------------------------------------------------
  // Configuration registers
  // ---------------------------------------------------------------
  logic [WIDTH-1:0] data_q, data_d;
  logic [WIDTH-1:0] dir_q, dir_d;
  logic [WIDTH-1:0] alt_q, alt_d;
  logic [WIDTH-1:0] fsel_q, fsel_d;
  logic [WIDTH-1:0] fext_q, fext_d;
  logic [WIDTH-1:0] pu_q, pu_d;
  logic [WIDTH-1:0] fall_q, fall_d;
  logic [WIDTH-1:0] rise_q, rise_d;
  logic             dbg_q, dbg_d;
  logic [WIDTH-1:0] view;

  always_comb begin
    view = (dir_q & sync2_q) | (~dir_q & data_q);
  end

  always_comb begin
    data_d = data_q;
    dir_d  = dir_q;
    alt_d  = alt_q;
    fsel_d = fsel_q;
    fext_d = fext_q;
    pu_d   = pu_q;
    fall_d = fall_q;
    rise_d = rise_q;
    dbg_d  = dbg_q & ~debug_pin_enable_clr;
    if (req.wr) begin
      unique case (req.sel)
        // Bit op merges into full port view
        gpp0_pkg::GPP0_SEL_DATA: data_d = req.bit_op ? merge(view, req) : merge(data_q, req);
        gpp0_pkg::GPP0_SEL_DIR:  dir_d  = merge(dir_q, req);
        gpp0_pkg::GPP0_SEL_ALT:  alt_d  = merge(alt_q, req);
        gpp0_pkg::GPP0_SEL_FSEL: fsel_d = merge(fsel_q, req);
        gpp0_pkg::GPP0_SEL_FEXT: fext_d = merge(fext_q, req);
        gpp0_pkg::GPP0_SEL_PU:   pu_d   = merge(pu_q, req);
        gpp0_pkg::GPP0_SEL_FALL: fall_d = merge(fall_q, req);
        gpp0_pkg::GPP0_SEL_RISE: rise_d = merge(rise_q, req);
      endcase
    end
  end

  // Clocked update, reset to input and port mode
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      data_q <= gpp0_pkg::DATA_RST[WIDTH-1:0];
      dir_q  <= gpp0_pkg::DIR_RST[WIDTH-1:0];
      alt_q  <= gpp0_pkg::ALT_RST[WIDTH-1:0];
      fsel_q <= gpp0_pkg::FSEL_RST[WIDTH-1:0];
      fext_q <= gpp0_pkg::FEXT_RST[WIDTH-1:0];
      pu_q   <= gpp0_pkg::PU_RST[WIDTH-1:0];
      fall_q <= gpp0_pkg::EDGE_RST[WIDTH-1:0];
      rise_q <= gpp0_pkg::EDGE_RST[WIDTH-1:0];
      dbg_q  <= gpp0_pkg::DBG_RST;
    end else begin
      data_q <= data_d;
      dir_q  <= dir_d;
      alt_q  <= alt_d;
      fsel_q <= fsel_d;
      fext_q <= fext_d;
      pu_q   <= pu_d;
      fall_q <= fall_d;
      rise_q <= rise_d;
      dbg_q  <= dbg_d;
    end
  end

  // ---------------------------------------------------------------
  // Read data
  // ---------------------------------------------------------------
  logic [7:0] rdata_q, rdata_d;
  logic       rvalid_q, rvalid_d;

  always_comb begin
    rvalid_d = req.rd;
    rdata_d  = rdata_q;
    if (req.rd) begin
      unique case (req.sel)
        gpp0_pkg::GPP0_SEL_DATA: rdata_d = widen(view);
        gpp0_pkg::GPP0_SEL_DIR:  rdata_d = widen(dir_q);
        gpp0_pkg::GPP0_SEL_ALT:  rdata_d = widen(alt_q);
        gpp0_pkg::GPP0_SEL_FSEL: rdata_d = widen(fsel_q);
        gpp0_pkg::GPP0_SEL_FEXT: rdata_d = widen(fext_q);
        gpp0_pkg::GPP0_SEL_PU:   rdata_d = widen(pu_q);
        gpp0_pkg::GPP0_SEL_FALL: rdata_d = widen(fall_q);
        gpp0_pkg::GPP0_SEL_RISE: rdata_d = widen(rise_q);
      endcase
      if (req.bit_op) begin
        rdata_d = {7'h00, rdata_d[req.bit_idx]};
      end
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      rdata_q  <= 8'h00;
      rvalid_q <= 1'b0;
    end else begin
      rdata_q  <= rdata_d;
      rvalid_q <= rvalid_d;
    end
  end

  // ---------------------------------------------------------------
  // Pin drive and alternate routing
  // ---------------------------------------------------------------
  logic [WIDTH-1:0] out_d, oe_d, pu_en_d;
  logic [WIDTH-1:0] out_q, oe_q, pu_en_q;
  logic             pd_q;
  gpp0_pkg::gpp0_alt_t alt_q2, alt_dd;

  always_comb begin
    out_d = data_q;
    // Driver on only in output mode
    oe_d  = ~dir_q;
    // Timer outputs replace latch in alternate mode
    if (alt_q[gpp0_pkg::TMR_B_POS]) begin
      out_d[gpp0_pkg::TMR_B_POS] = timer_channel_b_io_out;
    end
    if (alt_q[gpp0_pkg::TMR_A_POS]) begin
      out_d[gpp0_pkg::TMR_A_POS] = timer_channel_a_io_out;
    end
    // Debug reset input forces bit five input
    if (dbg_q) begin
      oe_d[gpp0_pkg::DBG_POS] = 1'b0;
    end
    pu_en_d = pu_q & dir_q;
    alt_dd.tmr_b_in     = alt_q[gpp0_pkg::TMR_B_POS] & sync2_q[gpp0_pkg::TMR_B_POS];
    alt_dd.tmr_a_in     = alt_q[gpp0_pkg::TMR_A_POS] & sync2_q[gpp0_pkg::TMR_A_POS];
    alt_dd.nmi_in       = alt_q[gpp0_pkg::NMI_POS] & sync2_q[gpp0_pkg::NMI_POS];
    alt_dd.ext_int0_in  = alt_q[gpp0_pkg::INT0_POS] & sync2_q[gpp0_pkg::INT0_POS];
    alt_dd.conv_trig_in = alt_q[gpp0_pkg::INT0_POS] & sync2_q[gpp0_pkg::INT0_POS];
    alt_dd.ext_int1_in  = alt_q[gpp0_pkg::INT1_POS] & sync2_q[gpp0_pkg::INT1_POS];
    // Debug reset regardless of alternate select
    alt_dd.dbg_reset_in = dbg_q & sync2_q[gpp0_pkg::DBG_POS];
    alt_dd.ext_int2_in  = ~dbg_q & alt_q[gpp0_pkg::DBG_POS] & sync2_q[gpp0_pkg::DBG_POS];
    alt_dd.ext_int3_in  = alt_q[gpp0_pkg::INT3_POS] & sync2_q[gpp0_pkg::INT3_POS];
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      out_q   <= '0;
      oe_q    <= '0;
      pu_en_q <= '0;
      pd_q    <= 1'b1;
      alt_q2  <= '0;
    end else begin
      out_q   <= out_d;
      oe_q    <= oe_d;
      pu_en_q <= pu_en_d;
      pd_q    <= dbg_d;
      alt_q2  <= alt_dd;
    end
  end

  // ---------------------------------------------------------------
  // Outputs
  // ---------------------------------------------------------------
  always_comb begin
    rdata                       = rdata_q;
    rvalid                      = rvalid_q;
    debug_pin_enable_bit        = dbg_q;
    pin_out                     = out_q;
    pin_oe                      = oe_q;
    pin_pullup_en               = pu_en_q;
    bit5_pulldown_en            = pd_q;
    alt_in                      = alt_q2;
    port_function_select_reg    = fsel_q;
    port_function_extension_reg = fext_q;
    falling_edge_select_reg     = fall_q;
    rising_edge_select_reg      = rise_q;
  end

endmodule

// [tb/gpp0_checker.sv]
// Port-level checker for the port 0 block
`timescale 1ns/10ps
module gpp0_checker #(
  parameter int unsigned WIDTH = gpp0_pkg::PORT_BITS
) (
  // Clock and reset
  input wire logic                clk,
  input wire logic                rstn,
  // Watched ports
  input wire gpp0_pkg::gpp0_req_t req,
  input wire logic                debug_pin_enable_clr,
  input wire logic [7:0]          rdata,
  input wire logic                rvalid,
  input wire logic                debug_pin_enable_bit,
  input wire logic [WIDTH-1:0]    pin_out,
  input wire logic [WIDTH-1:0]    pin_oe,
  input wire logic [WIDTH-1:0]    pin_pullup_en,
  input wire logic                bit5_pulldown_en
);
  // -------------------------------------------------------------
  // Properties
  // -------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rstn);
  sequence s_data_wr;
    req.wr && !req.bit_op && req.sel == gpp0_pkg::GPP0_SEL_DATA ##1 !req.wr;
  endsequence
  a_rd_answer: assert property (req.rd |=> rvalid)
    else $error("read not answered");
  a_rvalid_cause: assert property (rvalid |-> $past(req.rd))
    else $error("read answer without request");
  a_rdata_top: assert property (rvalid |-> rdata[7] == 1'b0)
    else $error("read bit seven set");
  a_write_drive: assert property (s_data_wr |=> ((pin_out ^ $past(req.wdata[WIDTH-1:0], 2)) & pin_oe) == '0)
    else $error("driven pin differs from written latch");
  a_pullup_out: assert property ((pin_pullup_en & pin_oe & $past(pin_pullup_en) & $past(pin_oe)) == '0)
    else $error("pull-up on an output pin");
  a_dbg_clear: assert property (debug_pin_enable_clr |-> ##[1:2] !debug_pin_enable_bit)
    else $error("debug enable not cleared");
  a_dbg_sticky: assert property (!debug_pin_enable_bit |=> !debug_pin_enable_bit)
    else $error("debug enable set again");
  a_pulldown_off: assert property ($fell(debug_pin_enable_bit) |-> ##[0:2] !bit5_pulldown_en)
    else $error("pull-down kept after debug release");
  a_bit5_held: assert property (debug_pin_enable_bit |-> !pin_oe[gpp0_pkg::DBG_POS])
    else $error("bit five driven while debug enabled");
endmodule

bind gpp0_port gpp0_checker #(.WIDTH(WIDTH)) u_gpp0_checker (.clk(clk), .rstn(rstn), .req(req),
  .debug_pin_enable_clr(debug_pin_enable_clr), .rdata(rdata), .rvalid(rvalid),
  .debug_pin_enable_bit(debug_pin_enable_bit), .pin_out(pin_out), .pin_oe(pin_oe),
  .pin_pullup_en(pin_pullup_en), .bit5_pulldown_en(bit5_pulldown_en));

// [tb/gpp0_pins.sv]
// Model of the circuitry outside the port 0 pins
`timescale 1ns/10ps
module gpp0_pins (
  // Clock
  input  wire logic       clk,
  // Device side
  input  wire logic [6:0] pin_out,
  input  wire logic [6:0] pin_oe,
  input  wire logic [6:0] pin_pullup_en,
  input  wire logic       bit5_pulldown_en,
  // Outside drivers
  input  wire logic [6:0] ext_en,
  input  wire logic [6:0] ext_val,
  output logic      [6:0] pin_lvl
);
  logic [6:0] last_q = 7'h00;
  always @(posedge clk) last_q <= pin_lvl;
  always_comb begin
    for (int i = 0; i < 7; i++) begin
      if (pin_oe[i]) pin_lvl[i] = pin_out[i];
      else if (ext_en[i]) pin_lvl[i] = ext_val[i];
      else if (pin_pullup_en[i]) pin_lvl[i] = 1'b1;
      else if (i == 5 && bit5_pulldown_en) pin_lvl[i] = 1'b0;
      else pin_lvl[i] = ~last_q[i];
    end
  end
endmodule

// [tb/test_gpp0_port.sv]
// Self-checking bench for the port 0 block
`timescale 1ns/10ps
module test_gpp0_port;
  logic                clk        = 1'b0;
  logic                rstn       = 1'b0;
  gpp0_pkg::gpp0_req_t req        = '0;
  logic                clr        = 1'b0;
  logic [6:0]          ext_en     = 7'h00;
  logic [6:0]          ext_val    = 7'h00;
  logic [1:0]          tmr        = 2'b00;
  int                  failures   = 0;
  int                  n_compared = 0;
  int                  cycles     = 0;
  int                  seed       = 28;
  logic [7:0]          rdata, got;
  logic                rvalid, dbg, pd;
  logic [6:0]          pin_in, pin_out, pin_oe, pu_en, d, w, v, pu, lat;
  gpp0_pkg::gpp0_alt_t alt;
  always #4 clk = ~clk;
  gpp0_port u_gpp0_port (.clk(clk), .rstn(rstn), .req(req), .debug_pin_enable_clr(clr), .rdata(rdata),
    .rvalid(rvalid), .debug_pin_enable_bit(dbg), .pin_in(pin_in), .pin_out(pin_out), .pin_oe(pin_oe),
    .pin_pullup_en(pu_en), .bit5_pulldown_en(pd), .timer_channel_a_io_out(tmr[1]),
    .timer_channel_b_io_out(tmr[0]), .alt_in(alt), .port_function_select_reg(),
    .port_function_extension_reg(), .falling_edge_select_reg(), .rising_edge_select_reg());
  gpp0_pins u_gpp0_pins (.clk(clk), .pin_out(pin_out), .pin_oe(pin_oe), .pin_pullup_en(pu_en),
    .bit5_pulldown_en(pd), .ext_en(ext_en), .ext_val(ext_val), .pin_lvl(pin_in));
  // -------------------------------------------------------------
  // Helpers
  // -------------------------------------------------------------
  function automatic logic [6:0] view(input logic [6:0] l, input logic [6:0] m, input logic [6:0] p);
    return (l & ~m) | (p & m);
  endfunction
  task automatic chk(input string nm, input logic [7:0] seen, input logic [7:0] exp);
    n_compared++;
    if (seen !== exp) begin
      failures++;
      $display("BAD %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic acc(input logic wr, input gpp0_pkg::gpp0_sel_t sel, input logic bop, input logic [2:0] idx,
                     input logic [7:0] wd);
    @(posedge clk);
    req <= '{wr: wr, rd: !wr, bit_op: bop, sel: sel, bit_idx: idx, wdata: wd};
    @(posedge clk);
    req <= '0;
    @(posedge clk);
    got = rdata;
    if (!wr) chk("rvalid", {7'h00, rvalid}, 8'h01);
    repeat (3) @(posedge clk);
  endtask
  task automatic conclude;
    $display("compared %0d failures %0d", n_compared, failures);
    if (failures == 0 && n_compared > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  always @(posedge clk) begin
    cycles++;
    if (cycles == 20000) begin
      failures++;
      conclude();
    end
  end
  // -------------------------------------------------------------
  // Scenarios
  // -------------------------------------------------------------
  initial begin
    repeat (3) @(posedge clk);
    rstn <= 1'b1;
    chk("dbg rst", {6'h00, dbg, pd}, 8'h03);
    chk("oe rst", {1'b0, pin_oe | pu_en}, 8'h00);
    acc(0, gpp0_pkg::GPP0_SEL_DIR, 0, 0, 0);
    chk("dir rst", got, 8'h7f);
    for (int s = 2; s < 8; s++) begin
      acc(0, gpp0_pkg::gpp0_sel_t'(s), 0, 0, 0);
      chk("cfg rst", got, 8'h00);
    end
    // function selects before alternate select, edges last
    for (int j = 1; j < 8; j++) begin
      int s;
      s = (j == 2) ? 3 : (j == 3) ? 4 : (j == 4) ? 2 : j;
      w = 7'($random(seed));
      acc(1, gpp0_pkg::gpp0_sel_t'(s), 0, 0, {1'b0, w});
      acc(0, gpp0_pkg::gpp0_sel_t'(s), 0, 0, 0);
      chk("cfg rw", got, {1'b0, w});
    end
    // unused alternates back to reset value
    acc(1, gpp0_pkg::GPP0_SEL_ALT, 0, 0, 8'h00);
    ext_en <= 7'h20;
    ext_val <= 7'h00;
    @(posedge clk) clr <= 1'b1;
    @(posedge clk) clr <= 1'b0;
    repeat (3) @(posedge clk);
    chk("dbg clr", {6'h00, dbg, pd}, 8'h00);
    for (int k = 0; k < 24; k++) begin
      d = 7'($random(seed));
      w = 7'($random(seed));
      v = 7'($random(seed));
      pu = 7'($random(seed));
      if (k == 0) d = 7'h7f;
      if (k == 1) d = 7'h00;
      ext_en <= d;
      ext_val <= v;
      tmr <= 2'($random(seed));
      acc(1, gpp0_pkg::GPP0_SEL_DIR, 0, 0, {1'b0, d});
      acc(1, gpp0_pkg::GPP0_SEL_PU, 0, 0, {1'b0, pu});
      acc(1, gpp0_pkg::GPP0_SEL_DATA, 0, 0, {1'b0, w});
      chk("oe", {1'b0, pin_oe}, {1'b0, ~d});
      chk("drive", {1'b0, pin_out & ~d}, {1'b0, w & ~d});
      chk("pullup", {1'b0, pu_en}, {1'b0, pu & d});
      acc(0, gpp0_pkg::GPP0_SEL_DATA, 0, 0, 0);
      chk("view", got, {1'b0, view(w, d, v)});
      lat = view(w, d, v);
      lat[k % 7] = w[0];
      acc(1, gpp0_pkg::GPP0_SEL_DATA, 1, 3'(k % 7), {7'h00, w[0]});
      acc(0, gpp0_pkg::GPP0_SEL_DATA, 0, 0, 0);
      chk("bitop", got, {1'b0, view(lat, d, v)});
    end
    ext_en <= 7'h7f;
    acc(1, gpp0_pkg::GPP0_SEL_DIR, 0, 0, 8'h7f);
    for (int a = 0; a < 4; a++) begin
      ext_val <= {4'h0, a[0], 2'b00};
      acc(1, gpp0_pkg::GPP0_SEL_ALT, 0, 0, {5'h00, a[1], 2'b00});
      chk("nmi", {7'h00, alt.nmi_in}, {7'h00, a[0] & a[1]});
    end
    conclude();
  end
endmodule
